// ==== hw/ehl_error_history_log.sv ====
// error history log: ten-entry snapshot history with sequential readout
// assumes the array is backed by retained storage across power loss; one clock

`timescale 1ns/1ns
`default_nettype none

//
// Contract
// - keep at most ten error entries
// - history survives power loss
// - sequential access only via read pointer
// - writing 1 to rewind resets pointer
// - pointer advances after entry delivered
// - past last entry, error code reads 0
// - position one oldest, ten newest
// - code read latches entry, advances pointer
// - snapshot captured at detection, never updated; an event arriving in the clear busy cycle is not stored
// - class is unsigned 16-bit, 0 to 4
// - current in 0.01 A steps
// - dc bus voltage in 0.1 V steps
// - timestamp seconds, 32 bits, max 536870911
// - clear writes 1, reads 0 when done
// - power-on count unsigned 32 bits
// - enable count since switch-on, 16 bits
// - enable to error time, 16 bits
// - qualifier word 16 bits, code dependent
// - temperatures and velocity signed 16 bits
// - rewind and clear act immediately; clear empties the log one cycle later, after the busy cycle
module ehl_error_history_log
    import ehl_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        arst_n_in,
    input  wire logic        err_event_in,
    input  wire ehl_entry_t  err_snapshot_in,
    input  wire ehl_req_t    req_in,
    output var  logic [31:0] rdata_out,
    output var  logic        rvalid_out,
    output var  logic [3:0]  entry_count_out,
    output var  logic        clear_busy_out
);

    typedef struct packed {
        ehl_entry_t [EHL_DEPTH-1:0] mem;
        ehl_entry_t                 hold;
        logic [3:0]                 count;
        logic [3:0]                 rptr;
        ehl_mode_t                  mode;
        logic [31:0]                rdata;
        logic                       rvalid;
    } ehl_state_t;

    ehl_state_t st;
    ehl_state_t next_st;
    ehl_entry_t clipped;

    // clip class and timestamp to their legal ranges at capture
    always_comb begin
        clipped = err_snapshot_in;
        if (err_snapshot_in.err_class > EHL_CLASS_MAX) begin
            clipped.err_class = EHL_CLASS_MAX;
        end
        if (err_snapshot_in.timestamp > EHL_TIMESTAMP_MAX) begin
            clipped.timestamp = EHL_TIMESTAMP_MAX;
        end
    end

    // next-state logic: capture, clear, rewind and parameter reads
    always_comb begin
        next_st        = st;
        next_st.rvalid = 1'b0;
        // clear takes one cycle; the busy flag lets the master poll for 0
        if (st.mode == EHL_CLEAR) begin
            next_st.count = EHL_RST_COUNT;
            next_st.rptr  = EHL_RST_COUNT;
            next_st.mode  = EHL_IDLE;
        end else if (err_event_in) begin
            // snapshot stored whole and never touched again
            if (st.count == EHL_DEPTH_W) begin
                for (int i = 0; i < EHL_DEPTH - 1; i++) begin
                    next_st.mem[i] = st.mem[i+1];
                end
                next_st.mem[EHL_DEPTH-1] = clipped;
            end else begin
                next_st.mem[st.count] = clipped;
                next_st.count         = st.count + 4'h1;
            end
        end
        if (req_in.wr) begin
            case (req_in.addr)
                EHL_ADDR_REWIND: begin
                    if (req_in.wdata[15:0] == EHL_CMD_ONE) begin
                        next_st.rptr = EHL_RST_COUNT;
                    end
                end
                EHL_ADDR_CLEAR: begin
                    if (req_in.wdata[15:0] == EHL_CMD_ONE) begin
                        next_st.mode = EHL_CLEAR;
                    end
                end
                default: begin
                end
            endcase
        end
        if (req_in.rd) begin
            next_st.rvalid = 1'b1;
            case (req_in.addr)
                EHL_ADDR_ERR_CODE: begin
                    // only sequential access; no index selection exists
                    if (st.rptr < st.count) begin
                        next_st.hold  = st.mem[st.rptr];
                        next_st.rdata = {16'h0000, st.mem[st.rptr].code};
                        next_st.rptr  = st.rptr + 4'h1;
                    end else begin
                        next_st.hold  = '0;
                        next_st.rdata = EHL_RST_DATA;
                    end
                end
                EHL_ADDR_ERR_CLASS:    next_st.rdata = {16'h0000, st.hold.err_class};
                EHL_ADDR_TIMESTAMP:    next_st.rdata = st.hold.timestamp;
                EHL_ADDR_QUALIFIER:    next_st.rdata = {16'h0000, st.hold.qualifier};
                EHL_ADDR_ENABLE_CYC:   next_st.rdata = {16'h0000, st.hold.enable_cycles};
                EHL_ADDR_ENABLE_TIME:  next_st.rdata = {16'h0000, st.hold.enable_time};
                EHL_ADDR_DC_BUS:       next_st.rdata = {16'h0000, st.hold.dc_bus};
                EHL_ADDR_VELOCITY:     next_st.rdata = {{16{st.hold.velocity[15]}}, st.hold.velocity};
                EHL_ADDR_CURRENT:      next_st.rdata = {16'h0000, st.hold.current};
                EHL_ADDR_PS_TEMP:      next_st.rdata = {{16{st.hold.ps_temp[15]}}, st.hold.ps_temp};
                EHL_ADDR_DEV_TEMP:     next_st.rdata = {{16{st.hold.dev_temp[15]}}, st.hold.dev_temp};
                EHL_ADDR_POWER_CYCLE:  next_st.rdata = st.hold.power_cycles;
                EHL_ADDR_CLEAR:        next_st.rdata = {31'h0, st.mode == EHL_CLEAR};
                EHL_ADDR_REWIND:       next_st.rdata = EHL_RST_DATA;
                default:               next_st.rdata = EHL_RST_DATA;
            endcase
        end
    end

    // state register; the history array models retained storage, so
    // reset here stands for first power-up only
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rdata_out       = st.rdata;
    assign rvalid_out      = st.rvalid;
    assign entry_count_out = st.count;
    assign clear_busy_out  = (st.mode == EHL_CLEAR);

    // checks
    a_count_bound: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        st.count <= EHL_DEPTH_W) else $error("entry count above ten");
    a_rewind_ptr: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        req_in.wr && req_in.addr == EHL_ADDR_REWIND && req_in.wdata[15:0] == 16'h0001
        && !(req_in.rd && req_in.addr == EHL_ADDR_ERR_CODE) |=> st.rptr == 4'h0)
        else $error("rewind did not reset pointer");
    a_ptr_advance: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        req_in.rd && req_in.addr == EHL_ADDR_ERR_CODE && st.rptr < st.count && !req_in.wr
        && !err_event_in && st.mode == EHL_IDLE |=> st.rptr == $past(st.rptr) + 4'h1)
        else $error("pointer did not advance");
    a_empty_zero: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        req_in.rd && req_in.addr == EHL_ADDR_ERR_CODE && st.rptr >= st.count
        |=> rvalid_out && rdata_out == 32'h0) else $error("code not zero past end");
    a_code_latch: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        req_in.rd && req_in.addr == EHL_ADDR_ERR_CODE && st.rptr < st.count
        |=> st.hold == $past(st.mem[st.rptr]) && rdata_out[15:0] == st.hold.code)
        else $error("entry not latched");
    a_class_range: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        err_event_in && st.mode == EHL_IDLE && st.count < EHL_DEPTH_W
        |=> st.mem[$past(st.count)].err_class <= 16'h0004) else $error("class out of range");
    a_clear_done: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        req_in.wr && req_in.addr == EHL_ADDR_CLEAR && req_in.wdata[15:0] == 16'h0001 && st.mode == EHL_IDLE
        |=> clear_busy_out ##1 !clear_busy_out && st.count == 4'h0) else $error("clear did not finish");
    a_shift_full: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        err_event_in && st.mode == EHL_IDLE && st.count == EHL_DEPTH_W
        |=> st.mem[0] == $past(st.mem[1]) && st.count == 4'ha) else $error("oldest not dropped");
    a_hold_stable: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        !(req_in.rd && req_in.addr == EHL_ADDR_ERR_CODE) |=> $stable(st.hold))
        else $error("holding buffer changed");
    // every read is answered one cycle later, whatever the address
    a_read_answer: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        req_in.rd |=> rvalid_out) else $error("read not answered");
    // a clipped timestamp never exceeds the counter's top value
    a_time_range: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        err_event_in && st.mode == EHL_IDLE && st.count < EHL_DEPTH_W
        |=> st.mem[$past(st.count)].timestamp <= EHL_TIMESTAMP_MAX) else $error("timestamp out of range");

    c_full: cover property (@(posedge clk_in) disable iff (!arst_n_in) st.count == 4'ha);
    c_wrap: cover property (@(posedge clk_in) disable iff (!arst_n_in)
        err_event_in && st.count == 4'ha);
    c_clear: cover property (@(posedge clk_in) disable iff (!arst_n_in) clear_busy_out);
    c_clip: cover property (@(posedge clk_in) disable iff (!arst_n_in)
        err_event_in && err_snapshot_in.err_class > EHL_CLASS_MAX);
    c_readout: cover property (@(posedge clk_in) disable iff (!arst_n_in)
        req_in.rd && req_in.addr == EHL_ADDR_ERR_CODE && st.rptr < st.count);

endmodule

`default_nettype wire

// ==== hw/ehl_pkg.sv ====
// package for the error history log: parameter addresses, entry layout, constants
// assumes a single clock domain and a simple parameter read/write port

package ehl_pkg;

    // parameter addresses as printed (not all multiples of four, kept as indices)
    localparam logic [15:0] EHL_ADDR_POWER_CYCLE   = 16'h3b04;
    localparam logic [15:0] EHL_ADDR_CLEAR         = 16'h3b08;
    localparam logic [15:0] EHL_ADDR_REWIND        = 16'h3b0a;
    localparam logic [15:0] EHL_ADDR_ERR_CODE      = 16'h3c02;
    localparam logic [15:0] EHL_ADDR_ERR_CLASS     = 16'h3c04;
    localparam logic [15:0] EHL_ADDR_TIMESTAMP     = 16'h3c06;
    localparam logic [15:0] EHL_ADDR_QUALIFIER     = 16'h3c08;
    localparam logic [15:0] EHL_ADDR_ENABLE_CYC    = 16'h3c0a;
    localparam logic [15:0] EHL_ADDR_ENABLE_TIME   = 16'h3c0c;
    localparam logic [15:0] EHL_ADDR_DC_BUS        = 16'h3c0e;
    localparam logic [15:0] EHL_ADDR_VELOCITY      = 16'h3c10;
    localparam logic [15:0] EHL_ADDR_CURRENT       = 16'h3c12;
    localparam logic [15:0] EHL_ADDR_PS_TEMP       = 16'h3c14;
    localparam logic [15:0] EHL_ADDR_DEV_TEMP      = 16'h3c16;

    // history depth as int and as 4-bit count, then field limits and constants
    localparam int          EHL_DEPTH              = 10;
    localparam logic [3:0]  EHL_DEPTH_W            = 4'ha;
    localparam logic [31:0] EHL_TIMESTAMP_MAX      = 32'h1fffffff;
    localparam logic [15:0] EHL_CLASS_MAX          = 16'h0004;
    localparam logic [15:0] EHL_CMD_ONE            = 16'h0001;
    localparam logic [3:0]  EHL_RST_COUNT          = 4'h0;
    localparam logic [31:0] EHL_RST_DATA           = 32'h0000_0000;

    // one stored snapshot
    typedef struct packed {
        logic [15:0] code;
        logic [15:0] err_class;
        logic [31:0] timestamp;
        logic [15:0] qualifier;
        logic [15:0] enable_cycles;
        logic [15:0] enable_time;
        logic [15:0] dc_bus;
        logic [15:0] velocity;
        logic [15:0] current;
        logic [15:0] ps_temp;
        logic [15:0] dev_temp;
        logic [31:0] power_cycles;
    } ehl_entry_t;

    // parameter access request
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [31:0] wdata;
    } ehl_req_t;

    typedef enum logic [1:0] {
        EHL_IDLE  = 2'b00,
        EHL_CLEAR = 2'b01
    } ehl_mode_t;

endpackage

// ==== sim/ehl_master_model.sv ====
// fieldbus master model: parameter reads, writes and clear polling
// assumes the log answers a read with a one-cycle rvalid pulse
`timescale 1ns/1ns
`default_nettype none
module ehl_master_model
    import ehl_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rvalid_in,
    input  wire logic [31:0] rdata_in,
    output var  ehl_req_t    req_out,
    output var  logic        timeout_out
);
    // idle at time zero so no stray access is taken
    initial begin
        req_out = '0;
        timeout_out = 1'b0;
    end
    // request held for one edge; answer taken at the edge that sees rvalid
    task automatic rd(input logic [15:0] addr, output logic [31:0] data);
        data = '0;
        @(posedge clk_in);
        req_out <= '{rd: 1'b1, wr: 1'b0, addr: addr, wdata: 32'h0};
        @(posedge clk_in);
        req_out <= '0;
        for (int n = 0; n < 4; n++) begin
            @(posedge clk_in);
            if (rvalid_in === 1'b1) begin
                data = rdata_in;
                return;
            end
        end
        timeout_out <= 1'b1;
    endtask
    task automatic wr(input logic [15:0] addr, input logic [31:0] data);
        @(posedge clk_in);
        req_out <= '{rd: 1'b0, wr: 1'b1, addr: addr, wdata: data};
        @(posedge clk_in);
        req_out <= '0;
    endtask
    // start a clear, then poll until the parameter reads zero
    task automatic clear_history();
        logic [31:0] d;
        wr(EHL_ADDR_CLEAR, 32'h1);
        for (int n = 0; n < 8; n++) begin
            rd(EHL_ADDR_CLEAR, d);
            if (d[15:0] === 16'h0) return;
        end
        timeout_out <= 1'b1;
    endtask
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
// testbench for the error history log: events, sequential readout, clear
// assumes the master model answers each read within a few cycles
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import ehl_pkg::*;
    typedef struct packed { logic [15:0] addr; logic [31:0] exp; } ehl_row_t;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        err_event = 1'b0;
    ehl_entry_t  snap = '0;
    ehl_entry_t  s0;
    ehl_req_t    req;
    logic [31:0] rdata;
    logic        rvalid;
    logic [3:0]  count;
    logic        busy;
    logic        timeout;
    logic [31:0] got;
    ehl_row_t    rows [11];
    int          fail_count = 0;
    int          samples_checked = 0;
    always #10 clk = ~clk;
    ehl_error_history_log ehl_error_history_log_inst (.clk_in(clk), .arst_n_in(arst_n), .err_event_in(err_event),
        .err_snapshot_in(snap), .req_in(req), .rdata_out(rdata), .rvalid_out(rvalid), .entry_count_out(count),
        .clear_busy_out(busy));
    ehl_master_model ehl_master_model_inst (.clk_in(clk), .rvalid_in(rvalid), .rdata_in(rdata), .req_out(req),
        .timeout_out(timeout));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [31:0] e);
        ehl_master_model_inst.rd(a, got);
        chk(got, e);
    endtask
    // one event pulse; the snapshot only matters in the pulse cycle
    task automatic log_event(input logic [15:0] code, input logic [15:0] cls = 16'h0004,
        input logic [31:0] ts = 32'h1fffffff);
        ehl_entry_t e;
        e = s0;
        e.code = code;
        e.err_class = cls;
        e.timestamp = ts;
        @(posedge clk);
        snap <= e;
        err_event <= 1'b1;
        @(posedge clk);
        err_event <= 1'b0;
    endtask
    task automatic complete_run();
        if (timeout === 1'b1) fail_count++;
        $display("checked %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // a stuck handshake ends the run instead of hanging it
    always @(posedge timeout) complete_run();
    initial begin
        s0 = '{code: 16'h1000, err_class: 16'h0004, timestamp: 32'h1fffffff, qualifier: 16'hffff,
            enable_cycles: 16'h0012, enable_time: 16'h0034, dc_bus: 16'h0f00, velocity: 16'hff38,
            current: 16'h0123, ps_temp: 16'hfff6, dev_temp: 16'h0028, power_cycles: 32'hffffffff};
        rows = '{'{EHL_ADDR_ERR_CLASS, 32'h4}, '{EHL_ADDR_TIMESTAMP, 32'h1fffffff},
            '{EHL_ADDR_QUALIFIER, 32'hffff}, '{EHL_ADDR_ENABLE_CYC, 32'h12}, '{EHL_ADDR_ENABLE_TIME, 32'h34},
            '{EHL_ADDR_DC_BUS, 32'hf00}, '{EHL_ADDR_VELOCITY, 32'hffffff38}, '{EHL_ADDR_CURRENT, 32'h123},
            '{EHL_ADDR_PS_TEMP, 32'hfffffff6}, '{EHL_ADDR_DEV_TEMP, 32'h28}, '{EHL_ADDR_POWER_CYCLE, 32'hffffffff}};
        repeat (8) @(posedge clk);
        chk({rdata[30:0], rvalid} | {26'h0, count, busy, 1'b0}, 32'h0);
        arst_n <= 1'b1;
        $display("test reset done");
        ehl_master_model_inst.wr(EHL_ADDR_REWIND, 32'h1);
        rd_chk(EHL_ADDR_ERR_CODE, 32'h0);
        for (int i = 0; i < 3; i++) log_event(16'h1000 + 16'(i));
        @(negedge clk);
        chk({28'h0, count}, 32'h3);
        // code first, then every element out of the holding buffer
        ehl_master_model_inst.wr(EHL_ADDR_REWIND, 32'h1);
        rd_chk(EHL_ADDR_ERR_CODE, 32'h1000);
        log_event(16'h1003);
        foreach (rows[i]) rd_chk(rows[i].addr, rows[i].exp);
        rd_chk(EHL_ADDR_ERR_CODE, 32'h1001);
        $display("test entry readout done");
        for (int i = 4; i < 12; i++) log_event(16'h1000 + 16'(i));
        @(negedge clk);
        chk({28'h0, count}, 32'ha);
        ehl_master_model_inst.wr(EHL_ADDR_REWIND, 32'h1);
        for (int i = 0; i < 10; i++) rd_chk(EHL_ADDR_ERR_CODE, 32'h1002 + i);
        rd_chk(EHL_ADDR_ERR_CODE, 32'h0);
        ehl_master_model_inst.wr(EHL_ADDR_REWIND, 32'h2);
        rd_chk(EHL_ADDR_ERR_CODE, 32'h0);
        rd_chk(EHL_ADDR_ERR_CLASS, 32'h0);
        $display("test overflow done");
        ehl_master_model_inst.wr(EHL_ADDR_CLEAR, 32'h1);
        @(negedge clk);
        chk({31'h0, busy}, 32'h1);
        ehl_master_model_inst.clear_history();
        @(negedge clk);
        chk({27'h0, count, busy}, 32'h0);
        ehl_master_model_inst.wr(EHL_ADDR_REWIND, 32'h1);
        rd_chk(EHL_ADDR_ERR_CODE, 32'h0);
        rd_chk(16'h3c18, 32'h0);
        $display("test clear done");
        // out-of-range class and timestamp must be clipped at capture
        log_event(16'h2000, 16'h0007, 32'hffffffff);
        ehl_master_model_inst.wr(EHL_ADDR_REWIND, 32'h1);
        rd_chk(EHL_ADDR_ERR_CODE, 32'h2000);
        rd_chk(EHL_ADDR_ERR_CLASS, 32'h4);
        rd_chk(EHL_ADDR_TIMESTAMP, 32'h1fffffff);
        $display("test clipping done");
        complete_run();
    end
endmodule
`default_nettype wire
